// *** rdl_readout.sv ***
// numeric readout latch: word counter, value latches, ready timer, lamps
`timescale 1ns/1ps
// Behaviour
// R1: binary value comes from data bits 1..10, only in words one and two.
// R2: first word strobe latches the most significant part of the value.
// R3: second word strobe latches the least significant part of the value.
// R4: after word two, convert value to bcd and show on three digits.
// R5: drive nine mode indicator outputs showing the functional display mode; sign and five take bit 15: each first word sets sign, five stays clear.
// R6: each display word is sixteen bits wide, bits numbered from zero.
// R7: ready drops on each word; processor sends only while ready is high.
// R8: every word is preceded by an encode strobe that advances the counter.
// R9: counter runs zero, one, two, three, four, then repeats three, four.
// R10: a word with bit 15 set resets the counter as first word.
// R11: word one holds weight-eight bits, word two weights one, two, four.
// R12: digits hold their old value until the next conversion completes.
module rdl_readout
   import rdl_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                reset,
   input  wire logic                encode_strobe,
   input  wire logic [DATA_W-1:0]   data_word,      // see R6
   output logic                     display_accept_ready,
   output logic [3:0]               word_count_outputs,
   output logic [DIGIT_W-1:0]       digit_units,
   output logic [DIGIT_W-1:0]       digit_tens,
   output logic [DIGIT_W-1:0]       digit_hundreds,
   output logic [LAMP_W-1:0]        mode_lamps
);
   rdl_conv_if cv ();

   rdl_word_e        word_reg;
   rdl_word_e        word_next;
   logic             ready_reg;
   logic             ready_next;
   logic [11:0]      rdy_cnt_reg;
   logic [11:0]      rdy_cnt_next;
   logic [2:0]       msb_reg;
   logic [2:0]       msb_next;
   logic [8:0]       lsb_reg;
   logic [8:0]       lsb_next;
   logic             start_reg;
   logic             start_next;
   logic [11:0]      dig_reg;
   logic [11:0]      dig_next;
   logic [LAMP_W-1:0] lamp_reg;
   logic [LAMP_W-1:0] lamp_next;
   logic             accept;
   logic             mark;
   logic [3:0]       u_code;
   logic [3:0]       t_code;
   logic [3:0]       h_code;
   logic [10:0]      weighted;

   // a word is only taken while ready is shown; others are dropped
   assign accept = encode_strobe && ready_reg;                 // see R7
   assign mark   = data_word[MARK_BIT];                        // see R10

   // word counter and the latches that follow it
   always_comb
   begin
      word_next  = word_reg;
      msb_next   = msb_reg;
      lsb_next   = lsb_reg;
      start_next = 1'b0;
      lamp_next  = lamp_reg;
      if (accept)                                              // see R8
      begin
         if (mark)
         begin
            word_next = RDL_W_ONE;                             // see R10
            // weight-eight bits of the three digits, see R2
            msb_next  = {data_word[W1_H8_BIT], data_word[W1_T8_BIT],
                         data_word[W1_U8_BIT]};                // see R11
            lamp_next[LAMP_POLAR] = data_word[W1_POLAR_BIT];   // see R5
            lamp_next[LAMP_RECT]  = !data_word[W1_POLAR_BIT];
            lamp_next[LAMP_LOG]   = data_word[W1_LOG_BIT];
            lamp_next[LAMP_DB]    = data_word[W1_LOG_BIT];
            lamp_next[LAMP_FREQ]  = data_word[W1_FREQ_BIT];
            lamp_next[LAMP_SIGN]  = data_word[W1_SIGN_BIT];
         end
         else
         begin
            case (word_reg)
               RDL_W_ONE:
               begin
                  word_next  = RDL_W_TWO;                      // see R9
                  // bits 1..9 carry weights one, two, four, see R3
                  lsb_next   = data_word[9:1];                 // see R1
                  start_next = 1'b1;                           // see R4
                  lamp_next[LAMP_ONE]  = data_word[W2_ONE_BIT];
                  lamp_next[LAMP_TWO]  = data_word[W2_TWO_BIT];
                  lamp_next[LAMP_FIVE] = data_word[W2_FIVE_BIT];
               end
               RDL_W_TWO:  word_next = RDL_W_THR;              // see R9
               RDL_W_THR:  word_next = RDL_W_FOUR;
               RDL_W_FOUR: word_next = RDL_W_THR;              // see R9
               // without a marked first word the stream is not framed
               default:    word_next = word_reg;
            endcase
         end
      end
   end

   // ready drops on each word and returns after the recovery time
   always_comb
   begin
      ready_next   = ready_reg;
      rdy_cnt_next = rdy_cnt_reg;
      if (accept)
      begin
         ready_next   = 1'b0;                                  // see R7
         rdy_cnt_next = READY_LOAD;
      end
      else if (!ready_reg)
      begin
         rdy_cnt_next = rdy_cnt_reg - 12'h001;
         if (rdy_cnt_reg == 12'h001)
            ready_next = 1'b1;
      end
   end

   // assemble the weighted value; weighted values above 999 saturate at 999
   assign u_code   = {msb_reg[0], lsb_reg[2:0]};              // see R11
   assign t_code   = {msb_reg[1], lsb_reg[5:3]};
   assign h_code   = {msb_reg[2], lsb_reg[8:6]};
   assign weighted = 11'(h_code) * 11'h064 + 11'(t_code) * 11'h00A
                     + 11'(u_code);
   assign cv.value = (weighted > MAX_SHOWN) ? MAX_SHOWN[9:0]
                                            : weighted[9:0];
   assign cv.start = start_reg;

   // displayed digits change only when a conversion completes
   always_comb
   begin
      dig_next = dig_reg;
      if (cv.done)
         dig_next = cv.digits;                                 // see R12
   end

   rdl_bcd_conv u_conv
   (
      .ref_clk (ref_clk),
      .reset   (reset),
      .cv      (cv)
   );

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         word_reg    <= RDL_W_IDLE;
         ready_reg   <= 1'b1;
         rdy_cnt_reg <= 12'h000;
         msb_reg     <= 3'h0;
         lsb_reg     <= 9'h000;
         start_reg   <= 1'b0;
         dig_reg     <= DIGITS_RESET;
         lamp_reg    <= LAMP_RESET;
      end
      else
      begin
         word_reg    <= word_next;
         ready_reg   <= ready_next;
         rdy_cnt_reg <= rdy_cnt_next;
         msb_reg     <= msb_next;
         lsb_reg     <= lsb_next;
         start_reg   <= start_next;
         dig_reg     <= dig_next;
         lamp_reg    <= lamp_next;
      end
   end

   // outputs straight from registers
   assign display_accept_ready = ready_reg;
   assign word_count_outputs   = word_reg[4:1];
   assign digit_units          = dig_reg[3:0];
   assign digit_tens           = dig_reg[7:4];
   assign digit_hundreds       = dig_reg[11:8];
   assign mode_lamps           = lamp_reg;

   // helper: length of the last ready-low stretch
   logic [12:0] low_len;
   always_ff @(posedge ref_clk)
   begin
      if (reset || ready_reg)
         low_len <= 13'h0000;
      else
         low_len <= low_len + 13'h0001;
   end

   a_ready_drop: assert property ( // see R7
      @(posedge ref_clk) disable iff (reset)
      accept |=> !display_accept_ready)
      else $error("ready stayed high after a word");
   a_ready_time: assert property ( // see R7
      @(posedge ref_clk) disable iff (reset)
      $rose(ready_reg) |-> $past(low_len) == 13'(READY_CYCLES - 1))
      else $error("ready low time is wrong");
   a_mark_restart: assert property ( // see R10
      @(posedge ref_clk) disable iff (reset)
      (accept && mark) |=> word_count_outputs == 4'h1)
      else $error("marked word did not restart the counter");
   a_count_wrap: assert property ( // see R9
      @(posedge ref_clk) disable iff (reset)
      (accept && !mark && word_reg == RDL_W_FOUR) |=> word_reg == RDL_W_THR)
      else $error("counter did not return to word three");
   a_count_step: assert property ( // see R8
      @(posedge ref_clk) disable iff (reset)
      (accept && !mark && word_reg == RDL_W_TWO) |=> word_reg == RDL_W_THR)
      else $error("counter did not step on encode");
   a_msb_latch: assert property ( // see R2
      @(posedge ref_clk) disable iff (reset)
      (accept && mark) |=> msb_reg == {$past(data_word[W1_H8_BIT]),
         $past(data_word[W1_T8_BIT]), $past(data_word[W1_U8_BIT])})
      else $error("weight-eight bits not latched");
   a_lsb_start: assert property ( // see R3
      @(posedge ref_clk) disable iff (reset)
      (accept && !mark && word_reg == RDL_W_ONE)
      |=> start_reg && lsb_reg == $past(data_word[9:1]))
      else $error("second word not latched or conversion not started");
   a_digits_hold: assert property ( // see R12
      @(posedge ref_clk) disable iff (reset)
      !cv.done |=> $stable(dig_reg))
      else $error("digits changed without a conversion");
   a_digits_show: assert property ( // see R4
      @(posedge ref_clk) disable iff (reset)
      cv.done |=> dig_reg == $past(cv.digits))
      else $error("converted digits not shown");
endmodule : rdl_readout

// *** rdl_pkg.sv ***
// package of constants and types for the numeric readout latch
package rdl_pkg;
   localparam int          DATA_W          = 16;
   localparam int          BIN_W           = 10;
   localparam int          DIGIT_W         = 4;
   localparam int          LAMP_W          = 9;
   // word counter reset marker
   localparam int          MARK_BIT        = 15;
   // first word: weight-eight bits and mode bits
   localparam int          W1_POLAR_BIT    = 1;
   localparam int          W1_LOG_BIT      = 2;
   localparam int          W1_FREQ_BIT     = 3;
   localparam int          W1_U8_BIT       = 4;
   localparam int          W1_T8_BIT       = 7;
   localparam int          W1_H8_BIT       = 10;
   localparam int          W1_SIGN_BIT     = 15;
   // second word: weight 1/2/4 fields and multiplier bits
   localparam int          W2_UNITS_LSB    = 1;
   localparam int          W2_TENS_LSB     = 4;
   localparam int          W2_HUND_LSB     = 7;
   localparam int          W2_ONE_BIT      = 13;
   localparam int          W2_TWO_BIT      = 14;
   localparam int          W2_FIVE_BIT     = 15;
   // lamp positions on the indicator output
   localparam int          LAMP_POLAR      = 0;
   localparam int          LAMP_RECT       = 1;
   localparam int          LAMP_LOG        = 2;
   localparam int          LAMP_DB         = 3;
   localparam int          LAMP_FREQ       = 4;
   localparam int          LAMP_SIGN       = 5;
   localparam int          LAMP_ONE        = 6;
   localparam int          LAMP_TWO        = 7;
   localparam int          LAMP_FIVE       = 8;
   localparam logic [8:0]  LAMP_RESET      = 9'h000;
   localparam logic [11:0] DIGITS_RESET    = 12'h000;
   // numeric limits of the three-digit readout
   localparam logic [10:0] MAX_SHOWN       = 11'h3E7;
   localparam logic [3:0]  BCD_ADJ_LIMIT   = 4'h5;
   localparam logic [3:0]  BCD_ADJ_ADD     = 4'h3;
   localparam logic [3:0]  SHIFT_LAST      = 4'h9;
   // ready recovery time after each accepted word
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          READY_TIME_NS   = 35000;
   localparam int          READY_CYCLES    =
      (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          RDY_CNT_W       = 12;
   localparam logic [11:0] READY_LOAD      = 12'(READY_CYCLES);
   // word counter states, one-hot
   typedef enum logic [4:0]
   {
      RDL_W_IDLE = 5'h01,
      RDL_W_ONE  = 5'h02,
      RDL_W_TWO  = 5'h04,
      RDL_W_THR  = 5'h08,
      RDL_W_FOUR = 5'h10
   } rdl_word_e;
endpackage : rdl_pkg

// *** rdl_conv_if.sv ***
// carrier between the readout control and its binary to bcd converter
`timescale 1ns/1ps
interface rdl_conv_if;
   logic        start;
   logic [9:0]  value;
   logic        done;
   logic [11:0] digits;
   modport ctrl (output start, output value, input done, input digits);
   modport conv (input start, input value, output done, output digits);
endinterface : rdl_conv_if

// *** rdl_bcd_conv.sv ***
// sequential binary to bcd converter, one shift per clock
`timescale 1ns/1ps
module rdl_bcd_conv
   import rdl_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset,
   rdl_conv_if.conv  cv
);
   logic        busy_reg;
   logic        busy_next;
   logic [3:0]  step_reg;
   logic [3:0]  step_next;
   logic [21:0] work_reg;
   logic [21:0] work_next;
   logic        done_reg;
   logic        done_next;
   logic [11:0] dig_reg;
   logic [11:0] dig_next;
   logic [21:0] adj;

   // double dabble: add three to any digit of five or more, then shift
   always_comb
   begin
      adj       = work_reg;
      busy_next = busy_reg;
      step_next = step_reg;
      work_next = work_reg;
      done_next = 1'b0;
      dig_next  = dig_reg;
      for (int i = 0; i < 3; i++)
      begin
         if (work_reg[BIN_W + 4*i +: 4] >= BCD_ADJ_LIMIT)
            adj[BIN_W + 4*i +: 4] = work_reg[BIN_W + 4*i +: 4]
                                    + BCD_ADJ_ADD;
      end
      if (!busy_reg && cv.start)
      begin
         busy_next = 1'b1;
         step_next = 4'h0;
         work_next = {DIGITS_RESET, cv.value};
      end
      else if (busy_reg)
      begin
         work_next = {adj[20:0], 1'b0};
         step_next = step_reg + 4'h1;
         if (step_reg == SHIFT_LAST)
         begin
            busy_next = 1'b0;
            done_next = 1'b1;   // see R4
            dig_next  = work_next[21:10];
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         busy_reg <= 1'b0;
         step_reg <= 4'h0;
         work_reg <= 22'h000000;
         done_reg <= 1'b0;
         dig_reg  <= DIGITS_RESET;
      end
      else
      begin
         busy_reg <= busy_next;
         step_reg <= step_next;
         work_reg <= work_next;
         done_reg <= done_next;
         dig_reg  <= dig_next;
      end
   end

   assign cv.done   = done_reg;
   assign cv.digits = dig_reg;

   a_conv_latency: assert property (  // see R4
      @(posedge ref_clk) disable iff (reset)
      (cv.start && !busy_reg) |-> ##11 done_reg)
      else $error("conversion did not finish in eleven cycles");
endmodule : rdl_bcd_conv

// *** rdl_host_model.sv ***
// host processor model that sends display words to the readout
`timescale 1ns/1ps
module rdl_host_model
   import rdl_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              display_accept_ready,
   output logic                   encode_strobe,
   output logic [DATA_W-1:0]      data_word
);
   // bus idles with no strobe
   initial
   begin
      encode_strobe = 1'b0;
      data_word     = 16'h0000;
   end

   // strobe and whole sixteen-bit word stand together for one cycle
   task automatic send_raw(input logic [DATA_W-1:0] w);
      @(posedge ref_clk);
      encode_strobe <= 1'b1;
      data_word     <= w;
      @(posedge ref_clk);
      encode_strobe <= 1'b0;
      data_word     <= ~w;   // released bus must not keep the old word
   endtask : send_raw

   // bounded wait, so a stuck flag shows as a failure and not a hang
   task automatic send_word(input logic [DATA_W-1:0] w);
      int n;
      n = 0;
      while (display_accept_ready !== 1'b1 && n < 5000)
      begin
         @(posedge ref_clk);
         n++;
      end
      send_raw(w);
   endtask : send_word
endmodule : rdl_host_model

// *** rdl_readout_tb_top.sv ***
// self-checking testbench of the numeric readout latch
`timescale 1ns/1ps
module rdl_readout_tb_top
   import rdl_pkg::*;
();
   typedef struct packed {
      logic [3:0]  h;
      logic [3:0]  t;
      logic [3:0]  u;
      logic [2:0]  mode;
      logic [1:0]  mult;
      logic [11:0] exp_digits;
      logic [8:0]  exp_lamps;
   } rdl_row_s;

   localparam int ROWS           = 6;
   localparam int TIMEOUT_CYCLES = 80000;

   logic              ref_clk = 1'b0;
   logic              reset   = 1'b1;
   logic              encode_strobe;
   logic [DATA_W-1:0] data_word;
   logic              display_accept_ready;
   logic [3:0]        word_count_outputs;
   logic [3:0]        digit_units;
   logic [3:0]        digit_tens;
   logic [3:0]        digit_hundreds;
   logic [8:0]        mode_lamps;
   int                mismatches = 0;
   int                cmp_count  = 0;
   int                cycle_count = 0;

   // digits h t u, mode freq/log/polar, mult two/one, expected outputs
   rdl_row_s rows [ROWS] = '{
      '{4'h9, 4'h9, 4'h9, 3'b001, 2'b01, 12'h999, 9'h061},
      '{4'h0, 4'h0, 4'h0, 3'b110, 2'b10, 12'h000, 9'h0BE},
      '{4'h8, 4'h8, 4'h8, 3'b011, 2'b11, 12'h888, 9'h0ED},
      '{4'h1, 4'h2, 4'h7, 3'b100, 2'b00, 12'h127, 9'h032},
      '{4'hF, 4'hF, 4'hF, 3'b000, 2'b00, 12'h999, 9'h022},
      '{4'h0, 4'hF, 4'h9, 3'b001, 2'b00, 12'h159, 9'h021}};

   always #5 ref_clk = ~ref_clk;

   rdl_readout i_dut (
      .ref_clk              (ref_clk),
      .reset                (reset),
      .encode_strobe        (encode_strobe),
      .data_word            (data_word),
      .display_accept_ready (display_accept_ready),
      .word_count_outputs   (word_count_outputs),
      .digit_units          (digit_units),
      .digit_tens           (digit_tens),
      .digit_hundreds       (digit_hundreds),
      .mode_lamps           (mode_lamps)
   );

   rdl_host_model i_host (
      .ref_clk              (ref_clk),
      .display_accept_ready (display_accept_ready),
      .encode_strobe        (encode_strobe),
      .data_word            (data_word)
   );

   // first word: marker, weight-eight bits and mode bits
   function automatic logic [15:0] word_one(input rdl_row_s r);
      word_one = 16'h8001 | (16'(r.h[3]) << 10) | (16'(r.t[3]) << 7) |
                 (16'(r.u[3]) << 4) | (16'(r.mode) << 1);
   endfunction : word_one

   // second word: weights one, two, four and multiplier bits
   function automatic logic [15:0] word_two(input rdl_row_s r);
      word_two = (16'(r.mult) << 13) | (16'(r.h[2:0]) << 7) |
                 (16'(r.t[2:0]) << 4) | (16'(r.u[2:0]) << 1);
   endfunction : word_two

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // shared reporting of one comparison
   task automatic note(input string nm, input bit ok,
                       input logic [11:0] e, input logic [11:0] g);
      cmp_count++;
      if (!ok)
      begin
         mismatches++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask : note

   task automatic chk_digits(input logic [11:0] e);
      logic [11:0] g;
      g = {digit_hundreds, digit_tens, digit_units};
      note("digits", g === e, e, g);
   endtask : chk_digits

   task automatic chk_lamps(input logic [8:0] e);
      note("lamps", mode_lamps === e, 12'(e), 12'(mode_lamps));
   endtask : chk_lamps

   task automatic chk_count(input logic [3:0] e);
      note("word count", word_count_outputs === e, 12'(e),
           12'(word_count_outputs));
   endtask : chk_count

   task automatic chk_ready(input logic e);
      note("ready", display_accept_ready === e, 12'(e),
           12'(display_accept_ready));
   endtask : chk_ready

   // hang guard, ceiling well above the expected run of about 60000
   always @(posedge ref_clk)
   begin
      cycle_count++;
      if (cycle_count == TIMEOUT_CYCLES)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   // main sequence
   initial
   begin
      logic [11:0] prev;
      prev = 12'h000;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk_ready(1'b1);
      chk_count(4'h0);
      chk_digits(12'h000);
      chk_lamps(9'h000);
      // unmarked word while idle: no count, but ready still drops
      i_host.send_word(16'h0E0E);
      #1;
      chk_count(4'h0);
      chk_ready(1'b0);
      for (int i = 0; i < ROWS; i++)
      begin
         i_host.send_word(word_one(rows[i]));
         #1;
         chk_count(4'h1);
         chk_ready(1'b0);
         i_host.send_word(word_two(rows[i]));
         #1;
         chk_count(4'h2);
         repeat (9) @(posedge ref_clk);
         #1;
         chk_digits(prev);
         repeat (5) @(posedge ref_clk);
         #1;
         chk_digits(rows[i].exp_digits);
         chk_lamps(rows[i].exp_lamps);
         prev = rows[i].exp_digits;
      end
      // third and fourth words repeat and leave value and lamps alone
      for (int k = 0; k < 4; k++)
      begin
         i_host.send_word(16'h7FFE);
         #1;
         chk_count(k[0] ? 4'h8 : 4'h4);
      end
      chk_digits(prev);
      chk_lamps(rows[ROWS-1].exp_lamps);
      // marked word mid-sequence restarts the counter
      i_host.send_word(16'h8000);
      #1;
      chk_count(4'h1);
      // rect and sign from the new first word, multipliers kept
      chk_lamps(9'h022);
      // strobe while not ready must not step the counter
      i_host.send_raw(16'h7FFE);
      #1;
      chk_count(4'h1);
      // second reset in mid-run
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      #1;
      chk_ready(1'b1);
      chk_count(4'h0);
      chk_digits(12'h000);
      chk_lamps(9'h000);
      tally_and_finish();
   end
endmodule : rdl_readout_tb_top
